//--- rtl/usc_pkg.sv
`default_nettype none
package usc_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int CHAR_W = 9;
   // Receive buffer entry: parity error, framing error, nine data bits
   localparam int RX_ENTRY_W = CHAR_W + 2;
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_TX_DATA = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_RX_DATA = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_MODE = 4'h6;
   // serial_status_control fields
   localparam int BIT_TXISEL1 = 15;
   localparam int BIT_TXINV = 14;
   localparam int BIT_TXISEL0 = 13;
   localparam int BIT_TXBRK = 11;
   localparam int BIT_TXEN = 10;
   localparam int BIT_TXBF = 9;
   localparam int BIT_TX_EMPTY_FLAG = 8;
   localparam int BIT_RXISEL1 = 7;
   localparam int BIT_RXISEL0 = 6;
   localparam int BIT_ADDRESS_DETECT_ENABLE = 5;
   localparam int BIT_RECEIVER_IDLE_FLAG = 4;
   localparam int BIT_PARITY_ERROR_FLAG = 3;
   localparam int BIT_FRAMING_ERROR_FLAG = 2;
   localparam int BIT_RX_OVERRUN_FLAG = 1;
   localparam int BIT_RXDA = 0;
   // serial_mode_register fields
   localparam int MODE_PARITY = 1;
   localparam int MODE_NINE = 2;
   localparam int MODE_RXINV = 4;
   localparam int MODE_INFRARED_ENCODE_ENABLE = 12;
   localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0110;
   localparam logic [DATA_W-1:0] MODE_RESET = 16'h0000;
   // Frame lengths in bit times, start and stop included
   localparam logic [3:0] TX_LEN_SHORT = 4'hA;
   localparam logic [3:0] TX_LEN_LONG = 4'hB;
   localparam logic [3:0] TX_LEN_BREAK = 4'hE;
   localparam logic [13:0] BREAK_FRAME = 14'h2000;
   // Bits sampled after the start bit
   localparam logic [3:0] RX_LEN_SHORT = 4'h9;
   localparam logic [3:0] RX_LEN_LONG = 4'hA;
   // Infrared pulse is 3/16 of a bit time
   localparam int IR_PULSE_NUM = 3;
   localparam int IR_PULSE_DEN = 16;
   typedef enum logic [1:0] {
      TXI_EACH = 2'b00,
      TXI_DONE = 2'b01,
      TXI_EMPTY = 2'b10,
      TXI_RSVD = 2'b11
   } usc_txi_type;
   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_SHIFT = 1'b1
   } usc_tx_state_type;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_BITS = 2'b10
   } usc_rx_state_type;
endpackage : usc_pkg
`default_nettype wire

//--- rtl/usc_rx_fifo.sv
`default_nettype none
module usc_rx_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   input wire logic flush,
   output logic [WIDTH-1:0] head,
   output logic [$clog2(DEPTH+1)-1:0] count,
   output logic full,
   output logic empty
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("usc_rx_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wp_reg;
   logic [PW-1:0] rp_reg;
   logic [CW-1:0] cnt_reg;

   assign full = cnt_reg == CW'(DEPTH);
   assign empty = cnt_reg == '0;
   assign count = cnt_reg;
   assign head = mem_reg[rp_reg];

   always_ff @(posedge clk) begin
      if (push && !full) begin
         mem_reg[wp_reg] <= push_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else if (flush) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg <= wp_reg + PW'(push && !full);
         rp_reg <= rp_reg + PW'(pop && !empty);
         cnt_reg <= cnt_reg + CW'(push && !full) - CW'(pop && !empty);
      end
   end
endmodule // usc_rx_fifo
`default_nettype wire

//--- rtl/usc_top.sv
// Function
// - Mode 10: interrupt when load empties buffer
// - Mode 01: interrupt when last character finishes
// - Mode 00: interrupt on every character load, not on break start
// - Plain line idles low when inverted, else high
// - Infrared line idles high when inverted, else low
// - Break: start, twelve zeros, stop
// - Break request self-clears after break completes
// - Enabled transmitter owns the transmit pin
// - Disable aborts, flushes buffer, releases pin
// - Buffer-full flag reads one when no slot
// - Empty flag needs shifter and buffer empty
// - Empty flag zero while busy or queued
// - Receive mode 11: interrupt at four characters
// - Receive mode 10: interrupt at three characters
// - Receive mode 0x: interrupt on every character stored in the buffer
// - Receive idle level follows receive inversion
// - First character after sleep wake invalid
// - Clearing overrun empties buffer and receiver
// - Data-available flag reads one when nonempty
// - Error flags belong to top character
// - Address detect filters only in nine-bit mode
`default_nettype none
module usc_top #(
   parameter int BIT_CYCLES = 16,
   parameter int TX_DEPTH = 4,
   parameter int RX_DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [usc_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [usc_pkg::DATA_W-1:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [usc_pkg::DATA_W-1:0] bus_rdata,
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   output logic tx_pin_select,
   output logic tx_irq,
   output logic rx_irq
);
   import usc_pkg::*;

   localparam int CW = $clog2(BIT_CYCLES);
   localparam int TPW = $clog2(TX_DEPTH);
   localparam int TCW = $clog2(TX_DEPTH+1);
   localparam int RCW = $clog2(RX_DEPTH+1);
   localparam int IR_RAW = (BIT_CYCLES * IR_PULSE_NUM) / IR_PULSE_DEN;
   localparam int IR_CYC = (IR_RAW < 1) ? 1 : IR_RAW;
   localparam logic [CW-1:0] CYC_TOP = CW'(BIT_CYCLES - 1);
   localparam logic [CW-1:0] CYC_HALF = CW'(BIT_CYCLES / 2 - 1);
   localparam logic [CW-1:0] IR_LAST = CW'(BIT_CYCLES - 1 - IR_CYC);
   localparam logic [RCW-1:0] RX_FULL_CNT = RCW'(RX_DEPTH);
   localparam logic [RCW-1:0] RX_3Q_CNT = RCW'(RX_DEPTH * 3 / 4);

   if (BIT_CYCLES < 4 || TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0
       || RX_DEPTH < 4 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_param
      $error("usc_top: unsupported BIT_CYCLES, TX_DEPTH or RX_DEPTH");
   end

   // Control state
   logic [1:0] txisel_reg;
   logic txinv_reg;
   logic brk_reg;
   logic txen_reg;
   logic [1:0] rxisel_reg;
   logic address_detect_enable_reg;
   logic rx_overrun_flag_reg;
   logic parity_reg;
   logic nine_reg;
   logic rxinv_reg;
   logic infrared_encode_enable_reg;
   logic [DATA_W-1:0] rdata_reg;

   // Bus decode
   wire wr_status = bus_write && bus_addr == OFS_STATUS;
   wire wr_txdata = bus_write && bus_addr == OFS_TX_DATA;
   wire wr_mode = bus_write && bus_addr == OFS_MODE;
   wire rd_rxdata = bus_read && bus_addr == OFS_RX_DATA;

   // Transmit buffer and shifter
   logic [CHAR_W-1:0] tx_mem_reg [TX_DEPTH];
   logic [TPW-1:0] tx_wp_reg;
   logic [TPW-1:0] tx_rp_reg;
   logic [TCW-1:0] tx_cnt_reg;
   usc_tx_state_type tx_state_reg;
   logic [13:0] tx_shift_reg;
   logic [3:0] tx_left_reg;
   logic [CW-1:0] tx_cyc_reg;
   logic tx_is_brk_reg;
   logic tx_pin_reg;
   logic tx_irq_reg;

   wire tx_idle = tx_state_reg == TX_IDLE;
   wire tx_full = tx_cnt_reg == TCW'(TX_DEPTH);
   wire tx_push = wr_txdata && txen_reg && !tx_full;
   // Abort takes effect at the disabling write itself, not a cycle later
   wire tx_stop = wr_status && !bus_wdata[BIT_TXEN];
   wire tx_run = txen_reg && !tx_stop;
   wire tx_load = tx_idle && tx_run && tx_cnt_reg != '0 && !brk_reg;
   wire brk_start = tx_idle && tx_run && brk_reg;
   wire [CHAR_W-1:0] tx_head = tx_mem_reg[tx_rp_reg];
   wire tx_long = nine_reg || parity_reg;
   wire tx_ninth = nine_reg ? tx_head[8] : (parity_reg ? ^tx_head[7:0] : 1'b1);
   wire [13:0] char_frame = {4'hF, tx_ninth, tx_head[7:0], 1'b0};
   wire [3:0] char_len = tx_long ? TX_LEN_LONG : TX_LEN_SHORT;
   wire tx_bit_end = !tx_idle && tx_cyc_reg == '0;
   wire tx_done = tx_bit_end && tx_left_reg == '0;
   wire tx_bit = tx_idle ? 1'b1 : tx_shift_reg[0];
   wire ir_pulse = !tx_idle && !tx_shift_reg[0] && tx_cyc_reg > IR_LAST;
   wire tx_empty_flag = tx_idle && tx_cnt_reg == '0;

   always_ff @(posedge clk) begin
      if (tx_push) begin
         tx_mem_reg[tx_wp_reg] <= bus_wdata[CHAR_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_wp_reg <= '0;
         tx_rp_reg <= '0;
         tx_cnt_reg <= '0;
      end else if (!tx_run) begin
         tx_wp_reg <= '0;
         tx_rp_reg <= '0;
         tx_cnt_reg <= '0;
      end else begin
         tx_wp_reg <= tx_wp_reg + TPW'(tx_push);
         tx_rp_reg <= tx_rp_reg + TPW'(tx_load);
         tx_cnt_reg <= tx_cnt_reg + TCW'(tx_push) - TCW'(tx_load);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 14'h3FFF;
         tx_left_reg <= 4'h0;
         tx_cyc_reg <= '0;
         tx_is_brk_reg <= 1'b0;
      end else if (!tx_run) begin
         tx_state_reg <= TX_IDLE;
         tx_is_brk_reg <= 1'b0;
      end else if (tx_load || brk_start) begin
         tx_state_reg <= TX_SHIFT;
         tx_shift_reg <= brk_start ? BREAK_FRAME : char_frame;
         tx_left_reg <= (brk_start ? TX_LEN_BREAK : char_len) - 4'h1;
         tx_cyc_reg <= CYC_TOP;
         tx_is_brk_reg <= brk_start;
      end else if (tx_bit_end) begin
         if (tx_left_reg == 4'h0) begin
            tx_state_reg <= TX_IDLE;
         end else begin
            tx_shift_reg <= {1'b1, tx_shift_reg[13:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
            tx_cyc_reg <= CYC_TOP;
         end
      end else if (!tx_idle) begin
         tx_cyc_reg <= tx_cyc_reg - CW'(1);
      end
   end

   wire tx_pin_next = txinv_reg ^ (infrared_encode_enable_reg ? ir_pulse : tx_bit);

   wire tx_irq_next = (txisel_reg == TXI_EACH && tx_load)
      || (txisel_reg == TXI_EMPTY && tx_load && tx_cnt_reg == TCW'(1) && !tx_push)
      || (txisel_reg == TXI_DONE && tx_done && tx_cnt_reg == '0 && !tx_push && !brk_reg);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_pin_reg <= 1'b1;
         tx_irq_reg <= 1'b0;
      end else begin
         tx_pin_reg <= tx_pin_next;
         tx_irq_reg <= tx_irq_next;
      end
   end

   assign tx_pin_select = txen_reg;
   assign serial_tx_pin = tx_pin_reg;
   assign tx_irq = tx_irq_reg;

   // Receiver: the pin is asynchronous, two flops before any use
   logic rx_meta_reg;
   logic rx_sync_reg;
   usc_rx_state_type rx_state_reg;
   logic [CW-1:0] rx_cyc_reg;
   logic [3:0] rx_left_reg;
   logic [9:0] rx_shift_reg;
   logic rx_irq_reg;
   wire [RX_ENTRY_W-1:0] rx_head;
   wire [RCW-1:0] rx_count;
   wire rx_full;
   wire rx_empty;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_meta_reg <= serial_rx_pin;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   wire rx_line = rx_sync_reg ^ rxinv_reg;
   wire rx_long = nine_reg || parity_reg;
   wire [3:0] rx_len = rx_long ? RX_LEN_LONG : RX_LEN_SHORT;
   wire [9:0] rx_frame = {rx_line, rx_shift_reg[9:1]};
   wire [8:0] rx_data9 = nine_reg ? rx_frame[8:0]
      : {1'b0, (rx_long ? rx_frame[7:0] : rx_frame[8:1])};
   wire rx_parity_error_flag = parity_reg && !nine_reg && ^rx_frame[8:0];
   wire rx_framing_error_flag = !rx_frame[9];
   wire rx_done = rx_state_reg == RX_BITS && rx_cyc_reg == '0 && rx_left_reg == 4'h0;
   wire rx_drop = address_detect_enable_reg && nine_reg && !rx_data9[8];
   wire rx_accept = rx_done && !rx_drop;
   wire rx_push = rx_accept && !rx_full;
   wire rx_overrun_flag_set = rx_accept && rx_full;
   // Set wins: an overrun in the clearing cycle keeps the flag and the data
   wire rx_overrun_flag_clr = wr_status && !bus_wdata[BIT_RX_OVERRUN_FLAG] && rx_overrun_flag_reg && !rx_overrun_flag_set;
   wire rx_pop = rd_rxdata && !rx_empty;
   wire [RCW-1:0] rx_cnt_after = rx_count + RCW'(rx_push) - RCW'(rx_pop);

   // no resync after clock stop; first character may be garbage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_state_reg <= RX_IDLE;
         rx_cyc_reg <= '0;
         rx_left_reg <= 4'h0;
         rx_shift_reg <= 10'h3FF;
      end else if (rx_overrun_flag_clr) begin
         rx_state_reg <= RX_IDLE;
      end else begin
         case (rx_state_reg)
            RX_IDLE: begin
               if (!rx_line) begin
                  rx_state_reg <= RX_START;
                  rx_cyc_reg <= CYC_HALF;
               end
            end
            RX_START: begin
               if (rx_cyc_reg != '0) begin
                  rx_cyc_reg <= rx_cyc_reg - CW'(1);
               end else if (rx_line) begin
                  rx_state_reg <= RX_IDLE;
               end else begin
                  rx_state_reg <= RX_BITS;
                  rx_cyc_reg <= CYC_TOP;
                  rx_left_reg <= rx_len - 4'h1;
               end
            end
            RX_BITS: begin
               if (rx_cyc_reg != '0) begin
                  rx_cyc_reg <= rx_cyc_reg - CW'(1);
               end else begin
                  rx_shift_reg <= rx_frame;
                  rx_cyc_reg <= CYC_TOP;
                  rx_left_reg <= rx_left_reg - 4'h1;
                  if (rx_left_reg == 4'h0) begin
                     rx_state_reg <= RX_IDLE;
                  end
               end
            end
            default: begin
               rx_state_reg <= RX_IDLE;
            end
         endcase
      end
   end

   // error bits travel with the character
   usc_rx_fifo #(
      .WIDTH(RX_ENTRY_W),
      .DEPTH(RX_DEPTH)
   ) u_rx_fifo (
      .clk(clk),
      .rst(rst),
      .push(rx_push),
      .push_data({rx_parity_error_flag, rx_framing_error_flag, rx_data9}),
      .pop(rx_pop),
      .flush(rx_overrun_flag_clr),
      .head(rx_head),
      .count(rx_count),
      .full(rx_full),
      .empty(rx_empty)
   );

   wire rx_irq_next = rx_push && (!rxisel_reg[1]
      || (rxisel_reg == 2'b10 && rx_cnt_after == RX_3Q_CNT)
      || (rxisel_reg == 2'b11 && rx_cnt_after == RX_FULL_CNT));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_irq_reg <= 1'b0;
      end else begin
         rx_irq_reg <= rx_irq_next;
      end
   end
   assign rx_irq = rx_irq_reg;

   wire brk_next = wr_status ? bus_wdata[BIT_TXBRK]
      : ((tx_done && tx_is_brk_reg) ? 1'b0 : brk_reg);
   wire rx_overrun_flag_next = rx_overrun_flag_set ? 1'b1 : (rx_overrun_flag_clr ? 1'b0 : rx_overrun_flag_reg);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txisel_reg <= {STATUS_RESET[BIT_TXISEL1], STATUS_RESET[BIT_TXISEL0]};
         txinv_reg <= STATUS_RESET[BIT_TXINV];
         txen_reg <= STATUS_RESET[BIT_TXEN];
         rxisel_reg <= STATUS_RESET[BIT_RXISEL1:BIT_RXISEL0];
         address_detect_enable_reg <= STATUS_RESET[BIT_ADDRESS_DETECT_ENABLE];
         brk_reg <= STATUS_RESET[BIT_TXBRK];
         rx_overrun_flag_reg <= STATUS_RESET[BIT_RX_OVERRUN_FLAG];
      end else begin
         if (wr_status) begin
            txisel_reg <= {bus_wdata[BIT_TXISEL1], bus_wdata[BIT_TXISEL0]};
            txinv_reg <= bus_wdata[BIT_TXINV];
            txen_reg <= bus_wdata[BIT_TXEN];
            rxisel_reg <= bus_wdata[BIT_RXISEL1:BIT_RXISEL0];
            address_detect_enable_reg <= bus_wdata[BIT_ADDRESS_DETECT_ENABLE];
         end
         brk_reg <= brk_next;
         rx_overrun_flag_reg <= rx_overrun_flag_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         parity_reg <= MODE_RESET[MODE_PARITY];
         nine_reg <= MODE_RESET[MODE_NINE];
         rxinv_reg <= MODE_RESET[MODE_RXINV];
         infrared_encode_enable_reg <= MODE_RESET[MODE_INFRARED_ENCODE_ENABLE];
      end else if (wr_mode) begin
         parity_reg <= bus_wdata[MODE_PARITY];
         nine_reg <= bus_wdata[MODE_NINE];
         rxinv_reg <= bus_wdata[MODE_RXINV];
         infrared_encode_enable_reg <= bus_wdata[MODE_INFRARED_ENCODE_ENABLE];
      end
   end

   // Read path
   // data available
   wire [DATA_W-1:0] status_value = {txisel_reg[1], txinv_reg, txisel_reg[0], 1'b0,
      brk_reg, txen_reg, tx_full, tx_empty_flag, rxisel_reg, address_detect_enable_reg,
      rx_state_reg == RX_IDLE, rx_head[RX_ENTRY_W-1] && !rx_empty,
      rx_head[RX_ENTRY_W-2] && !rx_empty, rx_overrun_flag_reg, !rx_empty};
   wire [DATA_W-1:0] mode_value = (DATA_W'(infrared_encode_enable_reg) << MODE_INFRARED_ENCODE_ENABLE)
      | (DATA_W'(rxinv_reg) << MODE_RXINV) | (DATA_W'(nine_reg) << MODE_NINE)
      | (DATA_W'(parity_reg) << MODE_PARITY);
   wire [DATA_W-1:0] rx_value = rx_empty ? '0 : DATA_W'(rx_head[CHAR_W-1:0]);
   wire [DATA_W-1:0] read_value = (bus_addr == OFS_STATUS) ? status_value
      : (bus_addr == OFS_MODE) ? mode_value
      : (bus_addr == OFS_RX_DATA) ? rx_value : '0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= bus_read ? read_value : '0;
      end
   end
   assign bus_rdata = rdata_reg;

   brk_clear_a:
   assert property (@(posedge clk) disable iff (rst)
      tx_done && tx_is_brk_reg && !wr_status |=> !brk_reg)
      else $error("break request not cleared after break");
   tx_abort_a:
   assert property (@(posedge clk) disable iff (rst)
      wr_status && !bus_wdata[BIT_TXEN] |=> tx_cnt_reg == '0 && tx_idle && !tx_pin_select)
      else $error("transmit disable did not abort");
   plain_idle_a:
   assert property (@(posedge clk) disable iff (rst)
      (tx_idle && !infrared_encode_enable_reg)[*2] |-> serial_tx_pin == !$past(txinv_reg))
      else $error("plain idle level wrong");
   ir_idle_a:
   assert property (@(posedge clk) disable iff (rst)
      (tx_idle && infrared_encode_enable_reg)[*2] |-> serial_tx_pin == $past(txinv_reg))
      else $error("infrared idle level wrong");
   tx_busy_a:
   assert property (@(posedge clk) disable iff (rst)
      tx_push |=> !tx_empty_flag)
      else $error("empty flag set with queued data");
   tx_each_a:
   assert property (@(posedge clk) disable iff (rst)
      tx_load && txisel_reg == TXI_EACH |=> tx_irq)
      else $error("missing transmit interrupt on load");
   rx_full_irq_a:
   assert property (@(posedge clk) disable iff (rst)
      rx_irq && $past(rxisel_reg) == 2'b11 |-> rx_count == RX_FULL_CNT)
      else $error("receive interrupt not at four characters");
   rx_overrun_flag_flush_a:
   assert property (@(posedge clk) disable iff (rst)
      rx_overrun_flag_clr |=> rx_empty && !rx_overrun_flag_reg && rx_state_reg == RX_IDLE)
      else $error("overrun clear did not flush receiver");
   rx_start_a:
   assert property (@(posedge clk) disable iff (rst)
      rx_state_reg == RX_IDLE && !rx_line && !rx_overrun_flag_clr |=> rx_state_reg == RX_START)
      else $error("start bit not detected");
endmodule // usc_top
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import usc_pkg::*;
   localparam int BC = 4;
   logic clk, rst, rx_line, serial_tx_pin, tx_pin_select, tx_irq, rx_irq;
   logic bus_write = 1'b0;
   logic bus_read = 1'b0;
   logic [ADDR_W-1:0] bus_addr = 4'h0;
   logic [DATA_W-1:0] bus_wdata = 16'h0000;
   logic [DATA_W-1:0] bus_rdata, v;
   int fails, cmp_count, txi_n, rxi_n, cyc;
   // Port logic holds the pin high while the serial port lets go of it
   wire logic tx_line = tx_pin_select ? serial_tx_pin : 1'b1;

   usc_top #(.BIT_CYCLES(BC)) usc_top_i (.clk(clk), .rst(rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
      .bus_rdata(bus_rdata), .serial_rx_pin(rx_line), .serial_tx_pin(serial_tx_pin),
      .tx_pin_select(tx_pin_select), .tx_irq(tx_irq), .rx_irq(rx_irq));
   usc_remote_node #(.BC(BC)) node_i (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));

   task automatic close_out();
      if (fails == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge clk);
      bus_write <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clk);
      bus_read <= 1'b0;
      #1 d = bus_rdata;
   endtask
   task automatic st(input logic [15:0] exp);
      rd(OFS_STATUS, v);
      check(v, exp);
   endtask

   task automatic t_reset();
      st(STATUS_RESET);
      check({15'h0000, tx_pin_select}, 16'h0000);
      check({15'h0000, serial_tx_pin}, 16'h0001);
   endtask
   // Mode 11 is left out on purpose: it is reserved
   task automatic t_txmodes();
      logic [7:0] c;
      logic [15:0] m [3] = '{16'h0400, 16'h8400, 16'h2400};
      logic [15:0] mid [3] = '{16'h0001, 16'h0001, 16'h0000};
      for (int i = 0; i < 3; i++) begin
         c = 8'(8'h41 + i);
         wr(OFS_STATUS, m[i]);
         #1 check({15'h0000, tx_pin_select}, 16'h0001);
         txi_n = 0;
         wr(OFS_TX_DATA, {8'h00, c});
         node_i.grab(10, v);
         check(v, {6'h00, 1'b1, c, 1'b0});
         check(16'(txi_n), mid[i]);
         repeat (BC + 6) @(posedge clk);
         check(16'(txi_n), 16'h0001);
         st(m[i] | 16'h0110);
      end
   endtask
   task automatic t_full();
      wr(OFS_STATUS, 16'h0400);
      for (int i = 0; i < 6; i++) wr(OFS_TX_DATA, 16'h0055);
      st(16'h0610);
      wr(OFS_STATUS, 16'h0000);
      st(16'h0110);
      check({15'h0000, tx_pin_select}, 16'h0000);
   endtask
   task automatic t_break();
      wr(OFS_STATUS, 16'h0C00);
      node_i.grab(14, v);
      check(v, {2'b00, BREAK_FRAME});
      repeat (BC + 4) @(posedge clk);
      st(16'h0510);
   endtask
   task automatic t_pol();
      logic [15:0] md [4] = '{16'h0000, 16'h0000, 16'h1000, 16'h1000};
      logic [15:0] sa [4] = '{16'h4400, 16'h0400, 16'h4400, 16'h0400};
      logic [15:0] ex [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000};
      for (int i = 0; i < 4; i++) begin
         wr(OFS_MODE, md[i]);
         wr(OFS_STATUS, sa[i]);
         repeat (4) @(posedge clk);
         check({15'h0000, serial_tx_pin}, ex[i]);
      end
      wr(OFS_MODE, 16'h0000);
      wr(OFS_STATUS, 16'h0000);
   endtask
   task automatic t_rx();
      logic [15:0] sa [3] = '{16'h0000, 16'h0080, 16'h00C0};
      logic [15:0] n3 [3] = '{16'h0003, 16'h0001, 16'h0000};
      logic [15:0] n4 [3] = '{16'h0004, 16'h0001, 16'h0001};
      for (int i = 0; i < 3; i++) begin
         wr(OFS_STATUS, sa[i]);
         rxi_n = 0;
         for (int k = 0; k < 4; k++) begin
            node_i.send({3'b111, 8'(8'h30 + k), 1'b0});
            repeat (6) @(posedge clk);
            if (k == 2) check(16'(rxi_n), n3[i]);
         end
         check(16'(rxi_n), n4[i]);
         st(sa[i] | 16'h0111);
         for (int k = 0; k < 4; k++) begin
            rd(OFS_RX_DATA, v);
            check(v, 16'(16'h0030 + k));
         end
         st(sa[i] | 16'h0110);
      end
      for (int k = 0; k < 5; k++) node_i.send({3'b111, 8'h60, 1'b0});
      st(16'h01D3);
      wr(OFS_STATUS, 16'h0000);
      st(16'h0110);
      rd(OFS_RX_DATA, v);
      check(v, 16'h0000);
   endtask
   task automatic t_ir();
      int lows;
      lows = 0;
      wr(OFS_MODE, 16'h1000);
      wr(OFS_STATUS, 16'h4400);
      wr(OFS_TX_DATA, 16'h0041);
      repeat (12 * BC) begin
         @(posedge clk);
         if (tx_line === 1'b0) lows++;
      end
      // Inverted infrared idles high: seven zero bits, one-cycle pulses at this bit time
      check(16'(lows), 16'h0007);
      wr(OFS_MODE, 16'h0000);
      wr(OFS_STATUS, 16'h0000);
   endtask
   task automatic t_err();
      wr(OFS_MODE, 16'h0002);
      node_i.send({3'b110, 8'h31, 1'b0});
      st(16'h0119);
      rd(OFS_RX_DATA, v);
      check(v, 16'h0031);
      wr(OFS_MODE, 16'h0000);
      node_i.send({3'b110, 8'h32, 1'b0});
      st(16'h0115);
      rd(OFS_RX_DATA, v);
      check(v, 16'h0032);
      wr(OFS_MODE, 16'h0004);
      rd(OFS_MODE, v);
      check(v, 16'h0004);
      wr(OFS_STATUS, 16'h0020);
      node_i.send({3'b110, 8'h33, 1'b0});
      node_i.send({3'b111, 8'h34, 1'b0});
      st(16'h0131);
      rd(OFS_RX_DATA, v);
      check(v, 16'h0134);
      wr(OFS_MODE, 16'h0000);
      wr(OFS_STATUS, 16'h0000);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Whole run needs about 1600 cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cyc++;
      if (tx_irq === 1'b1) txi_n++;
      if (rx_irq === 1'b1) rxi_n++;
      if (cyc == 6000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_txmodes();
      t_full();
      t_break();
      t_pol();
      t_ir();
      t_rx();
      t_err();
      close_out();
   end
endmodule // tb_top
`default_nettype wire

//--- tb/usc_remote_node.sv
`default_nettype none
module usc_remote_node #(
   parameter int BC = 4
) (
   input wire logic clk,
   input wire logic tx_line,
   output var logic rx_line
);
   // idle high level
   // The node drives the line from time zero, so it never floats between frames
   initial rx_line = 1'b1;
   // Frame bits go out LSB first; spare top bits are idle ones
   task automatic send(input logic [11:0] f);
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         rx_line <= f[i];
         repeat (BC - 1) @(posedge clk);
      end
      repeat (BC) @(posedge clk);
   endtask
   // Samples mid-bit from the start edge; gives up after a bounded wait
   task automatic grab(input int n, output logic [15:0] v);
      int w;
      v = '0;
      w = 0;
      while (tx_line !== 1'b0 && w < 400) begin
         @(posedge clk);
         w++;
      end
      repeat (BC / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         v[i] = tx_line;
         if (i < n - 1) repeat (BC) @(posedge clk);
      end
   endtask
endmodule // usc_remote_node
`default_nettype wire
